/* File: hw/adstat_pkg.sv */
// Package of offsets, fields, reset values and helpers for the statistics.
// Functional notes
// - Consecutive results differing by more than the delta limit set the delta flag.
// - Variance register bits 30..0 hold the read-only variance; bit 31 reads zero.
// - Control bits 6..4 pick block size: 0=128, 1=64, 2=32, 3=16, 4=8.
// - Control bit 0 enables statistics; bits 11..7 hold the deviation setting.
// - Mean register low 16 bits hold the read-only block mean.
`default_nettype none
package adstat_pkg;
    localparam int          ADDR_W       = 14;
    // Register byte offsets.
    localparam logic [13:0] OFS_DELTA    = 14'h20B8;
    localparam logic [13:0] OFS_VAR      = 14'h21C0;
    localparam logic [13:0] OFS_CTRL     = 14'h21C4;
    localparam logic [13:0] OFS_MEAN     = 14'h21C8;
    localparam logic [13:0] OFS_FLAGS    = 14'h21D0;
    localparam logic [13:0] OFS_MASK     = 14'h21D4;
    // Reset values.
    localparam logic [31:0] RST_REG      = 32'h0000_0000;
    // Control register fields.
    localparam int          CTRL_EN_BIT  = 0;
    localparam int          CTRL_SZ_LO   = 4;
    localparam int          CTRL_SZ_HI   = 6;
    localparam int          CTRL_DEV_HI  = 11;
    localparam logic [31:0] CTRL_WMASK   = 32'h0000_0FFF;
    // Interrupt flag positions.
    localparam int          FLG_STATS    = 0;
    localparam int          FLG_DELTA    = 6;
    localparam logic [31:0] FLG_IMPL     = 32'h0000_0041;
    // Field widths.
    localparam int          RES_W        = 16;
    localparam int          VAR_W        = 31;

    // Block size select to log2 of the sample count; reserved codes mean 8.
    function automatic logic [2:0] adstat_shift(input logic [2:0] sel);
        case (sel)
            3'h0:    adstat_shift = 3'h7;
            3'h1:    adstat_shift = 3'h6;
            3'h2:    adstat_shift = 3'h5;
            3'h3:    adstat_shift = 3'h4;
            default: adstat_shift = 3'h3;
        endcase
    endfunction : adstat_shift

    // Index of the last sample of a block of 2**sh samples.
    function automatic logic [6:0] adstat_last(input logic [2:0] sh);
        logic [7:0] n;
        n = 8'h01 << sh;
        adstat_last = 7'(n - 8'h01);
    endfunction : adstat_last
endpackage : adstat_pkg
`default_nettype wire

/* File: hw/adstat_delta.sv */
// Consecutive result delta checker.
`timescale 1ns/10ps
`default_nettype none
module adstat_delta (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [15:0] conversion_result,
    input  wire logic        result_valid,
    input  wire logic [15:0] delta_limit_value,
    output logic             delta_hit
);
    import adstat_pkg::*;

    logic [15:0] prev;
    logic        have_prev;
    logic [15:0] gap;

    // Magnitude of the step, so a fall counts as much as a rise.
    always_comb begin
        if (conversion_result > prev) begin
            gap = conversion_result - prev;
        end else begin
            gap = prev - conversion_result;
        end
    end

    // The first result after reset has no partner and never flags.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev      <= 16'h0000;
            have_prev <= 1'b0;
            delta_hit <= 1'b0;
        end else begin
            delta_hit <= 1'b0;
            if (result_valid) begin
                prev      <= conversion_result;
                have_prev <= 1'b1;
                delta_hit <= have_prev && (gap > delta_limit_value);
            end
        end
    end

    property p_no_false_hit;
        @(posedge pclk) disable iff (!presetn)
        delta_hit |-> $past(result_valid) && ($past(gap) > $past(delta_limit_value));
    endproperty
    a_no_false_hit: assert property (p_no_false_hit) else $error("delta hit without step");
endmodule : adstat_delta
`default_nettype wire

/* File: hw/adstat_accum.sv */
// Block accumulator producing mean and variance of the ADC results.
`timescale 1ns/10ps
`default_nettype none
module adstat_accum (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        enable,
    input  wire logic        restart,
    input  wire logic [2:0]  shift,
    input  wire logic [15:0] conversion_result,
    input  wire logic        result_valid,
    output logic             block_done,
    output logic [15:0]      mean,
    output logic [30:0]      variance
);
    import adstat_pkg::*;

    logic [6:0]  cnt;
    logic [22:0] sum;
    logic [38:0] sumsq;
    logic [22:0] next_sum;
    logic [38:0] next_sumsq;
    logic [15:0] next_mean;
    logic [31:0] next_var;
    logic        take;

    // Sums including the current sample; the variance uses E[x^2]-mean^2.
    always_comb begin
        take       = enable && !restart && result_valid;
        next_sum   = sum + 23'(conversion_result);
        next_sumsq = sumsq + 39'(conversion_result) * 39'(conversion_result);
        next_mean  = 16'(next_sum >> shift);
        next_var   = 32'(next_sumsq >> shift)
                   - 32'(next_mean) * 32'(next_mean);
    end

    // Disabling or reconfiguring discards a partial block.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt   <= 7'h00;
            sum   <= 23'h000000;
            sumsq <= 39'h00_0000_0000;
        end else if (!enable || restart) begin
            cnt   <= 7'h00;
            sum   <= 23'h000000;
            sumsq <= 39'h00_0000_0000;
        end else if (take) begin
            if (cnt == adstat_last(shift)) begin
                cnt   <= 7'h00;
                sum   <= 23'h000000;
                sumsq <= 39'h00_0000_0000;
            end else begin
                cnt   <= cnt + 7'h01;
                sum   <= next_sum;
                sumsq <= next_sumsq;
            end
        end
    end

    // Results move only on the last sample of a block.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_done <= 1'b0;
            mean       <= 16'h0000;
            variance   <= 31'h0000_0000;
        end else begin
            block_done <= take && (cnt == adstat_last(shift));
            if (take && (cnt == adstat_last(shift))) begin
                mean     <= next_mean;
                variance <= next_var[30:0];
            end
        end
    end

    property p_result_hold;
        @(posedge pclk) disable iff (!presetn)
        !block_done |-> $stable(mean) && $stable(variance);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("results moved mid block");

    property p_block_len;
        @(posedge pclk) disable iff (!presetn)
        block_done |-> $past(cnt) == adstat_last($past(shift));
    endproperty
    a_block_len: assert property (p_block_len) else $error("block ended at wrong count");
endmodule : adstat_accum
`default_nettype wire

/* File: hw/adstat_top.sv */
// APB register block with delta check, statistics and interrupt logic.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module adstat_top (
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    input  wire logic [adstat_pkg::ADDR_W-1:0]  paddr,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [31:0]                    pwdata,
    output logic [31:0]                         prdata,
    output logic                                pready,
    output logic                                pslverr,
    input  wire logic [15:0]                    conversion_result,
    input  wire logic                           result_valid,
    output logic                                irq
);
    import adstat_pkg::*;

    logic [15:0] delta_limit_value;
    logic [11:0] statistics_control;
    logic [31:0] irq_flag_reg_a;
    logic [31:0] irq_mask;
    logic [31:0] next_flags;
    logic [31:0] next_mask;
    logic [31:0] rd_val;
    logic        rd_hit;
    logic        access;
    logic        wr;
    logic        ctrl_wr;
    logic        delta_hit;
    logic        block_done;
    logic [15:0] mean;
    logic [30:0] variance;
    logic [2:0]  shift;

    // A transfer completes on the access cycle in which pready is high.
    assign access  = psel && penable && pready;
    assign wr      = access && pwrite;
    assign ctrl_wr = wr && (paddr == OFS_CTRL);
    assign shift   = adstat_shift(statistics_control[CTRL_SZ_HI:CTRL_SZ_LO]);

    adstat_delta u_delta (
        .pclk              (pclk),
        .presetn           (presetn),
        .conversion_result (conversion_result),
        .result_valid      (result_valid),
        .delta_limit_value (delta_limit_value),
        .delta_hit         (delta_hit)
    );

    adstat_accum u_accum (
        .pclk              (pclk),
        .presetn           (presetn),
        .enable            (statistics_control[CTRL_EN_BIT]),
        .restart           (ctrl_wr),
        .shift             (shift),
        .conversion_result (conversion_result),
        .result_valid      (result_valid),
        .block_done        (block_done),
        .mean              (mean),
        .variance          (variance)
    );

    // Read multiplexer; reserved bits read as zero.
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        if (paddr == OFS_DELTA) begin
            rd_val = {16'h0000, delta_limit_value};
        end else if (paddr == OFS_VAR) begin
            rd_val = {1'b0, variance};
        end else if (paddr == OFS_CTRL) begin
            rd_val = {20'h00000, statistics_control};
        end else if (paddr == OFS_MEAN) begin
            rd_val = {16'h0000, mean};
        end else if (paddr == OFS_FLAGS) begin
            rd_val = irq_flag_reg_a;
        end else if (paddr == OFS_MASK) begin
            rd_val = irq_mask;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Answer after the setup cycle, so every transfer has no wait state.
    // Read data is captured at setup, while the address is already stable.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= RST_REG;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !rd_hit;
            if (psel && !penable) begin
                prdata <= pwrite ? RST_REG : rd_val;
            end
        end
    end

    // Delta limit register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            delta_limit_value <= RST_REG[15:0];
        end else if (wr && (paddr == OFS_DELTA)) begin
            delta_limit_value <= pwdata[15:0];
        end
    end

    // Statistics control; the deviation setting is stored for software.
    // Any write restarts the block so a size change never mixes two sizes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            statistics_control <= RST_REG[11:0];
        end else if (ctrl_wr) begin
            statistics_control <= pwdata[CTRL_DEV_HI:0] & CTRL_WMASK[11:0];
        end
    end

    // Mask value after this edge, so a mask write moves irq at once.
    always_comb begin
        next_mask = irq_mask;
        if (wr && (paddr == OFS_MASK)) begin
            next_mask = pwdata & FLG_IMPL;
        end
    end

    // Interrupt mask, same layout as the flag register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= RST_REG;
        end else begin
            irq_mask <= next_mask;
        end
    end

    // Sticky flags: write one to clear, but a new event in the same cycle
    // wins so that no event is lost to a racing clear.
    always_comb begin
        next_flags = irq_flag_reg_a;
        if (wr && (paddr == OFS_FLAGS)) begin
            next_flags = next_flags & ~pwdata;
        end
        next_flags[FLG_DELTA] = next_flags[FLG_DELTA] | delta_hit;
        next_flags[FLG_STATS] = next_flags[FLG_STATS] | block_done;
        next_flags = next_flags & FLG_IMPL;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_flag_reg_a <= RST_REG;
        end else begin
            irq_flag_reg_a <= next_flags;
        end
    end

    // Level interrupt, registered so the output has no decode glitches.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_flags & next_mask);
        end
    end

    // A qualifying step shows in the flag register two edges after the sample.
    property p_delta_flag;
        @(posedge pclk) disable iff (!presetn)
        result_valid && u_delta.have_prev
            && (u_delta.gap > delta_limit_value)
            |-> ##2 irq_flag_reg_a[FLG_DELTA];
    endproperty
    a_delta_flag: assert property (p_delta_flag) else $error("delta flag missed");

    property p_var_read;
        @(posedge pclk) disable iff (!presetn)
        pready && !pwrite && (paddr == OFS_VAR)
            |-> prdata == {1'b0, $past(variance)};
    endproperty
    a_var_read: assert property (p_var_read) else $error("bad variance read");

    property p_size_write;
        @(posedge pclk) disable iff (!presetn)
        ctrl_wr |=> statistics_control[CTRL_SZ_HI:CTRL_SZ_LO]
            == $past(pwdata[CTRL_SZ_HI:CTRL_SZ_LO]);
    endproperty
    a_size_write: assert property (p_size_write) else $error("size not stored");

    property p_disabled_quiet;
        @(posedge pclk) disable iff (!presetn)
        !statistics_control[CTRL_EN_BIT] |=> !block_done;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("stats ran off");

    property p_mean_read;
        @(posedge pclk) disable iff (!presetn)
        pready && !pwrite && (paddr == OFS_MEAN)
            |-> prdata == {16'h0000, $past(mean)};
    endproperty
    a_mean_read: assert property (p_mean_read) else $error("bad mean read");

    property p_done_irq;
        @(posedge pclk) disable iff (!presetn)
        block_done && next_mask[FLG_STATS] |=> irq_flag_reg_a[FLG_STATS] && irq;
    endproperty
    a_done_irq: assert property (p_done_irq) else $error("block end not flagged");

    property p_apb_answer;
        @(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("apb answer timing");

    property p_irq_level;
        @(posedge pclk) disable iff (!presetn)
        |(irq_flag_reg_a & irq_mask) |-> irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq low with flag");

    // Nothing unmasked pending means the interrupt line is low.
    property p_irq_quiet;
        @(posedge pclk) disable iff (!presetn)
        !(|(irq_flag_reg_a & irq_mask)) |-> !irq;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet)
        else $error("irq high with nothing due");

    // An unmapped address answers with the error flag.
    property p_unmapped_err;
        @(posedge pclk) disable iff (!presetn)
        psel && !penable && !rd_hit |=> pslverr;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err)
        else $error("no slave error");

    // A refused read returns zero data.
    property p_err_rdata;
        @(posedge pclk) disable iff (!presetn)
        pready && pslverr && !pwrite |-> prdata == 32'h0000_0000;
    endproperty
    a_err_rdata: assert property (p_err_rdata)
        else $error("error read not zero");

    // Write transfers show zero on the read data lines.
    property p_write_rdata;
        @(posedge pclk) disable iff (!presetn)
        pready && pwrite |-> prdata == 32'h0000_0000;
    endproperty
    a_write_rdata: assert property (p_write_rdata)
        else $error("write returned data");

    // A write of one clears the delta flag when no new step races it.
    property p_flag_clear;
        @(posedge pclk) disable iff (!presetn)
        wr && (paddr == OFS_FLAGS) && pwdata[FLG_DELTA] && !delta_hit
            |=> !irq_flag_reg_a[FLG_DELTA];
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("delta flag not cleared");

    // A step in the same cycle as the clear keeps the flag set.
    property p_set_wins;
        @(posedge pclk) disable iff (!presetn)
        wr && (paddr == OFS_FLAGS) && delta_hit |=> irq_flag_reg_a[FLG_DELTA];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost to clear");

    // The delta limit takes the low half of the written word.
    property p_delta_store;
        @(posedge pclk) disable iff (!presetn)
        wr && (paddr == OFS_DELTA)
            |=> delta_limit_value == $past(pwdata[15:0]);
    endproperty
    a_delta_store: assert property (p_delta_store)
        else $error("delta limit not stored");

    // The enable bit follows the last control write.
    property p_enable_store;
        @(posedge pclk) disable iff (!presetn)
        ctrl_wr
            |=> statistics_control[CTRL_EN_BIT] == $past(pwdata[CTRL_EN_BIT]);
    endproperty
    a_enable_store: assert property (p_enable_store)
        else $error("enable not stored");

    // Only implemented mask bits are kept.
    property p_mask_store;
        @(posedge pclk) disable iff (!presetn)
        wr && (paddr == OFS_MASK)
            |=> irq_mask == ($past(pwdata) & FLG_IMPL);
    endproperty
    a_mask_store: assert property (p_mask_store)
        else $error("mask not stored");

    property p_cv_delta;
        @(posedge pclk) disable iff (!presetn)
        delta_hit ##1 irq;
    endproperty
    c_cv_delta: cover property (p_cv_delta);

    property p_cv_block;
        @(posedge pclk) disable iff (!presetn)
        block_done && (shift == 3'h3);
    endproperty
    c_cv_block: cover property (p_cv_block);

    property p_cv_clear;
        @(posedge pclk) disable iff (!presetn)
        wr && (paddr == OFS_FLAGS) && (delta_hit || block_done);
    endproperty
    c_cv_clear: cover property (p_cv_clear);

    property p_cv_slverr;
        @(posedge pclk) disable iff (!presetn)
        pready && pslverr;
    endproperty
    c_cv_slverr: cover property (p_cv_slverr);

    property p_cv_block_max;
        @(posedge pclk) disable iff (!presetn)
        block_done && (shift == 3'h7);
    endproperty
    c_cv_block_max: cover property (p_cv_block_max);
endmodule : adstat_top
`default_nettype wire

/* File: testbench/adstat_adc_src.sv */
// Model of the ADC result path that feeds the statistics block.
`timescale 1ns/10ps
`default_nettype none
module adstat_adc_src (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        push,
    input  wire logic [15:0] push_data,
    input  wire logic        slow,
    output logic             result_valid,
    output logic [15:0]      conversion_result,
    output logic             idle
);
    logic [15:0] pend[$];

    // Emit queued results back to back, or every other cycle when slow.
    // Off the strobe the data lines toggle, so a sampler that ignores the
    // strobe sees garbage rather than a lucky copy of the last result.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_valid      <= 1'b0;
            conversion_result <= 16'h0000;
            idle              <= 1'b1;
        end else begin
            if (push) pend.push_back(push_data);
            if (pend.size() != 0 && !(slow && result_valid)) begin
                conversion_result <= pend.pop_front();
                result_valid      <= 1'b1;
            end else begin
                conversion_result <= ~conversion_result;
                result_valid      <= 1'b0;
            end
            idle <= pend.size() == 0;
        end
    end
endmodule : adstat_adc_src
`default_nettype wire

/* File: testbench/test_adstat_top.sv */
// Self-checking bench for the ADC delta check and statistics block.
`timescale 1ns/10ps
`default_nettype none
module test_adstat_top;
    import adstat_pkg::*;
    typedef struct packed {logic [31:0] e; logic [31:0] m; logic r;} adstat_note_s;
    logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic         pwrite = 1'b0, push = 1'b0, slow = 1'b0;
    logic         pready, pslverr, irq, rv, idle;
    logic [13:0]  paddr = 14'h0000;
    logic [31:0]  pwdata = 32'h0000_0000, prdata, cv;
    logic [31:0]  seed = 32'h0000_E730;
    logic [15:0]  cr, v, push_data = 16'h0000;
    logic [15:0]  smp[$];
    logic [63:0]  sum, sq, mn, vr;
    int           err_count = 0, cmp_count = 0, n;
    adstat_note_s notes[$], nt;
    logic [13:0]  ofs[6] = '{OFS_DELTA, OFS_VAR, OFS_CTRL, OFS_MEAN,
                             OFS_FLAGS, OFS_MASK};

    adstat_top u_adstat_top (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conversion_result(cr), .result_valid(rv), .irq(irq));
    adstat_adc_src u_adstat_adc_src (.pclk(pclk), .presetn(presetn),
        .push(push), .push_data(push_data), .slow(slow), .result_valid(rv),
        .conversion_result(cr), .idle(idle));

    // Free-running 200 MHz clock.
    initial begin
        forever #2.5 pclk = ~pclk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    // Looked at on the completing edge, where the read data is taken.
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            nt = notes.pop_front();
            chk("prdata", nt.e & nt.m, prdata & nt.m);
            chk("pslverr", {31'h0, nt.r}, {31'h0, pslverr});
        end
    end

    // Hold the request until an edge samples pready high, then release.
    task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [13:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [13:0] a, input logic [31:0] e,
                      input logic [31:0] m, input logic r);
        notes.push_back({e, m, r});
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd

    task automatic irqchk(input logic e);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask : irqchk

    // Hand the queued samples to the source model and let them drain.
    task automatic feed();
        foreach (smp[i]) begin
            @(posedge pclk);
            push      <= 1'b1;
            push_data <= smp[i];
        end
        @(posedge pclk);
        push <= 1'b0;
        @(negedge pclk);
        while (idle !== 1'b1) @(negedge pclk);
        repeat (4) @(posedge pclk);
    endtask : feed

    // A hang would otherwise stall the run; the span is several full runs.
    initial begin
        #20000;
        err_count++;
        tally_and_finish();
    end

    // Main sequence.
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ofs[i]) rd(ofs[i], RST_REG, 32'hFFFF_FFFF, 1'b0);
        rd(14'h0004, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
        wr(OFS_CTRL, 32'hFFFF_FFFF);
        rd(OFS_CTRL, 32'h0000_0FFF, 32'hFFFF_FFFF, 1'b0);
        wr(OFS_VAR, 32'hFFFF_FFFF);
        wr(OFS_MEAN, 32'hFFFF_FFFF);
        rd(OFS_VAR, 32'h0000_0000, 32'hFFFF_FFFF, 1'b0);
        rd(OFS_MEAN, 32'h0000_0000, 32'hFFFF_FFFF, 1'b0);
        wr(OFS_DELTA, 32'hFFFF_FFFF);
        rd(OFS_DELTA, 32'h0000_FFFF, 32'hFFFF_FFFF, 1'b0);
        $display("test registers done");
        // Step of exactly the limit, then one over it in each direction.
        wr(OFS_CTRL, 32'h0000_0000);
        wr(OFS_DELTA, 32'h0000_0064);
        wr(OFS_MASK, 32'h0000_0040);
        smp = '{16'h03E8, 16'h044C};
        feed();
        rd(OFS_FLAGS, 32'h0000_0000, 32'h0000_0040, 1'b0);
        irqchk(1'b0);
        smp = '{16'h04B1};
        feed();
        rd(OFS_FLAGS, 32'h0000_0040, 32'h0000_0040, 1'b0);
        irqchk(1'b1);
        wr(OFS_FLAGS, 32'h0000_0040);
        irqchk(1'b0);
        smp = '{16'h044C};
        feed();
        irqchk(1'b1);
        wr(OFS_MASK, 32'h0000_0000);
        irqchk(1'b0);
        rd(OFS_FLAGS, 32'h0000_0040, 32'h0000_0040, 1'b0);
        $display("test delta done");
        // Every block size, with a discarded partial block before each.
        wr(OFS_DELTA, 32'h0000_FFFF);
        for (int k = 0; k < 5; k++) begin
            n = 128 >> k;
            cv = (rnd() & 32'h0000_0F8E) | 32'(k << 4) | 32'h0000_0001;
            slow <= k[0];
            wr(OFS_FLAGS, 32'h0000_0041);
            wr(OFS_CTRL, cv);
            smp = '{16'h1234, 16'hFEDC, 16'h0F0F};
            feed();
            wr(OFS_CTRL, cv);
            rd(OFS_CTRL, cv, 32'hFFFF_FFFF, 1'b0);
            smp.delete();
            sum = 64'h0;
            sq = 64'h0;
            repeat (n) begin
                v = 16'(rnd());
                smp.push_back(v);
                sum += 64'(v);
                sq += 64'(v) * 64'(v);
            end
            feed();
            mn = sum / n;
            vr = sq / n - mn * mn;
            rd(OFS_MEAN, 32'(mn), 32'hFFFF_FFFF, 1'b0);
            rd(OFS_VAR, {1'b0, vr[30:0]}, 32'hFFFF_FFFF, 1'b0);
            rd(OFS_FLAGS, 32'h0000_0001, 32'h0000_0001, 1'b0);
            $display("test block of %0d done", n);
        end
        // Disabled statistics leave the last results alone.
        wr(OFS_CTRL, 32'h0000_0040);
        smp = '{16'h0001, 16'hFFFF, 16'h0002, 16'hFFFE,
                16'h0003, 16'hFFFD, 16'h0004, 16'hFFFC};
        feed();
        rd(OFS_MEAN, 32'(mn), 32'hFFFF_FFFF, 1'b0);
        $display("test disable done");
        tally_and_finish();
    end
endmodule : test_adstat_top
`default_nettype wire
